//--- hw/acr_pkg.sv
// shared constants and types for the converter register and result block
package acr_pkg;
   // widths
   localparam int CFG_W = 8;
   localparam int RES_W = 24;
   localparam int RED_W = 19;
   localparam int SMALL_W = 16;
   localparam int DATA_W = 96;
   localparam int CMD_W = 8;
   localparam int BITCNT_W = 10;
   localparam int TAG_W = 3;
   localparam int CHTAG_W = 2;
   localparam int SYNC_W = 6;
   // device control bit positions
   localparam int PDN_BIT = 7;
   localparam int SOFT_RST_BIT = 6;
   localparam int FULL_RES_BIT = 5;
   localparam int XTAL_BIT = 4;
   localparam int FAULT_DIS_BIT = 3;
   localparam int REFBUF_PD_BIT = 2;
   localparam logic [CFG_W-1:0] CFG_RESET = 8'h00;
   localparam logic [CFG_W-1:0] CFG_WRITE_MASK = 8'hFC;
   // command byte
   localparam int CMD_READ_BIT = 7;
   localparam logic [6:0] ADDR_CFG = 7'h60;
   localparam logic [6:0] ADDR_DATA = 7'h70;
   localparam logic [BITCNT_W-1:0] CMD_LAST = 10'h007;
   localparam logic [BITCNT_W-1:0] CMD_BITS = 10'h008;
   // synchroniser lanes and their idle levels
   localparam int SY_CS = 5;
   localparam int SY_SCLK = 4;
   localparam int SY_DIN = 3;
   localparam int SY_CASC = 2;
   localparam int SY_FAULT = 1;
   localparam int SY_XIN = 0;
   localparam logic [SYNC_W-1:0] SYNC_IDLE = 6'h30;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int FAULT_RECOVERY_NS = 1570000;
   localparam int FAULT_RECOVERY_CYCLES = FAULT_RECOVERY_NS / CLK_PERIOD_NS;
   localparam int RECOV_W = 18;
   localparam int READY_HIGH_NS = 40;
   localparam int READY_HIGH_CYCLES = (READY_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READY_W = 4;
   // serial port states
   typedef enum logic [5:0]
   {
      ST_IDLE = 6'h01,
      ST_CMD = 6'h02,
      ST_RD_CFG = 6'h04,
      ST_RD_DATA = 6'h08,
      ST_WR_CFG = 6'h10,
      ST_SKIP = 6'h20
   } acr_state_type;
endpackage

//--- hw/acr_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module acr_sync
#(
   parameter int W = 1,
   parameter logic [W-1:0] RESET_VAL = '0
)
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // data
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   // first stage feeds only the second
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta_reg <= RESET_VAL;
         q_reg <= RESET_VAL;
      end
      else
      begin
         meta_reg <= d_in;
         q_reg <= meta_reg;
      end
   end

   assign q_out = q_reg;
endmodule // acr_sync
`default_nettype wire

//--- hw/acr_result_format.sv
// packs four channel results into the 96-bit result word
`timescale 1ns/1ps
`default_nettype none
module acr_result_format
#(
   parameter bit SIXTEEN_BIT = 1'b0
)
(
   // inputs
   input wire logic [acr_pkg::RES_W*4-1:0] results_in,
   input wire logic [acr_pkg::TAG_W-1:0] position_tag_in,
   input wire logic full_res_in,
   // packed word
   output logic [acr_pkg::DATA_W-1:0] word_out
);
   // one 24-bit slot: channel 0 first, highest bits
   function automatic logic [acr_pkg::RES_W-1:0] slot
   (
      input logic [acr_pkg::RES_W-1:0] res,
      input logic [acr_pkg::TAG_W-1:0] tag,
      input logic [acr_pkg::CHTAG_W-1:0] ch,
      input logic full
   );
      logic [acr_pkg::RES_W-1:0] s;
      s = '0;
      if (SIXTEEN_BIT)
         s = {res[acr_pkg::RES_W-1 -: acr_pkg::SMALL_W], 3'h0, tag, ch};
      else if (full)
         s = res;
      else
         s = {res[acr_pkg::RES_W-1 -: acr_pkg::RED_W], tag, ch};
      return s;
   endfunction

   always_comb
   begin
      word_out = '0;
      for (int i = 0; i < 4; i++)
      begin
         // channel tag equals channel number
         word_out[acr_pkg::DATA_W-1-acr_pkg::RES_W*i -: acr_pkg::RES_W] =
            slot(results_in[acr_pkg::RES_W*(4-i)-1 -: acr_pkg::RES_W],
                 position_tag_in, 2'(i), full_res_in);
      end
   end
endmodule // acr_result_format
`default_nettype wire

//--- hw/acr_top.sv
// control register, serial port and result register of the converter
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// How it works
// - control bit 7 powers down oscillator, fault circuits and bandgap; clearing restores.
// - writing one to bit 6 restores defaults and realigns sampling and output.
// - bit 5 set gives 24-bit results; clear gives 19-bit plus tags.
// - bit 4 runs the oscillator and drives clock out; clear leaves it undriven.
// - bit 3 clear holds output clipped for recovery time after overvoltage.
// - bit 2 set powers down the reference buffer.
// - every channel result is two's complement.
// - each converter supplies 96 bits per result read.
// - an unread result is overwritten by the next conversion.
// - 19-bit results drop low bits of the full result.
// - 19-bit slots hold result, position tag, channel tag; channel 0 highest.
// - position tag is 000 on the converter nearest the host.
// - channel tags are 00, 01, 10 and 11 for channels 0 to 3.
// - 24-bit format packs four untagged results, channel 0 highest.
// - 16-bit variant slot: result, three zeros, position tag, channel tag.
// - control register is all zeros after reset or soft reset.
// - control reads move 96 bits per cascaded converter: the control byte, then 88 zeros.
// - serial clock idles high; data sampled on the first (falling) edge.
// - falling edge on ready output marks new results.
module acr_top
#(
   parameter bit SIXTEEN_BIT = 1'b0,
   parameter int FAULT_RECOVERY_CYCLES = acr_pkg::FAULT_RECOVERY_CYCLES
)
(
   // clock and reset
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   // serial port
   input wire logic cs_n_in,
   input wire logic sclk_in,
   input wire logic din_in,
   input wire logic casc_data_in,
   output logic dout_out,
   output logic dout_oe_out,
   output logic result_ready_out_n,
   // conversion results from the modulators
   input wire logic conv_valid_in,
   input wire logic [acr_pkg::RES_W-1:0] channel0_result_in,
   input wire logic [acr_pkg::RES_W-1:0] channel1_result_in,
   input wire logic [acr_pkg::RES_W-1:0] channel2_result_in,
   input wire logic [acr_pkg::RES_W-1:0] channel3_result_in,
   input wire logic [acr_pkg::TAG_W-1:0] cascade_position_tag_in,
   // analog side
   input wire logic fault_in,
   input wire logic clock_input_pin_in,
   output logic buffered_clock_out_out,
   output logic buffered_clock_out_oe_out,
   output logic power_down_bit_out,
   output logic osc_enable_out,
   output logic fault_circuit_enable_out,
   output logic bandgap_enable_out,
   output logic ref_buffer_enable_out,
   output logic full_resolution_select_out,
   output logic realign_out,
   output logic clip_active_out
);
   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [acr_pkg::SYNC_W-1:0] sync_s;
   logic cs_n_s;
   logic sclk_s;
   logic din_s;
   logic casc_s;
   logic fault_s;
   logic xin_s;

   acr_sync
   #(
      .W(acr_pkg::SYNC_W),
      .RESET_VAL(acr_pkg::SYNC_IDLE)
   )
   u_sync
   (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .d_in({cs_n_in, sclk_in, din_in, casc_data_in, fault_in, clock_input_pin_in}),
      .q_out(sync_s)
   );

   assign cs_n_s = sync_s[acr_pkg::SY_CS];
   assign sclk_s = sync_s[acr_pkg::SY_SCLK];
   assign din_s = sync_s[acr_pkg::SY_DIN];
   assign casc_s = sync_s[acr_pkg::SY_CASC];
   assign fault_s = sync_s[acr_pkg::SY_FAULT];
   assign xin_s = sync_s[acr_pkg::SY_XIN];

   ////////////////////////////////////////////////////////////////////////////
   // serial port
   acr_pkg::acr_state_type state_reg;
   acr_pkg::acr_state_type state_next;
   logic sclk_prev_reg;
   logic cs_prev_reg;
   logic [acr_pkg::BITCNT_W-1:0] cnt_reg;
   logic [acr_pkg::BITCNT_W-1:0] cnt_next;
   logic [acr_pkg::CMD_W-1:0] rx_reg;
   logic [acr_pkg::CMD_W-1:0] rx_next;
   logic [acr_pkg::DATA_W-1:0] tx_reg;
   logic [acr_pkg::DATA_W-1:0] tx_next;
   logic dout_reg;
   logic dout_next;
   logic dout_oe_reg;
   logic sclk_fall;
   logic sclk_rise;
   logic cs_start;
   logic cs_end;
   logic [acr_pkg::CMD_W-1:0] rx_shift;
   logic [acr_pkg::BITCNT_W-1:0] data_bits;
   logic cfg_write_go;
   logic data_read_go;
   logic [acr_pkg::CFG_W-1:0] cfg_reg;
   logic [acr_pkg::DATA_W-1:0] fmt_word;

   // clock idles high, so the first edge of each bit falls
   assign sclk_fall = sclk_prev_reg & ~sclk_s;
   assign sclk_rise = ~sclk_prev_reg & sclk_s;
   assign cs_start = cs_prev_reg & ~cs_n_s;
   assign cs_end = ~cs_prev_reg & cs_n_s;
   assign rx_shift = {rx_reg[acr_pkg::CMD_W-2:0], din_s};
   assign data_bits = cnt_reg - acr_pkg::CMD_BITS;
   // whole bytes only; a frame cut short leaves the register alone
   assign cfg_write_go = cs_end && state_reg == acr_pkg::ST_WR_CFG && cnt_reg > acr_pkg::CMD_BITS
      && data_bits[2:0] == 3'h0;
   assign data_read_go = state_reg == acr_pkg::ST_CMD && sclk_fall && cnt_reg == acr_pkg::CMD_LAST
      && rx_shift == {1'b1, acr_pkg::ADDR_DATA};

   always_comb
   begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      rx_next = rx_reg;
      tx_next = tx_reg;
      dout_next = dout_reg;
      if (cs_n_s)
      begin
         state_next = acr_pkg::ST_IDLE;
      end
      else if (cs_start)
      begin
         state_next = acr_pkg::ST_CMD;
         cnt_next = '0;
      end
      else if (sclk_fall)
      begin
         rx_next = rx_shift;
         cnt_next = cnt_reg + 10'h001;
         case (state_reg)
            acr_pkg::ST_CMD:
            begin
               if (cnt_reg == acr_pkg::CMD_LAST)
               begin
                  if (rx_shift == {1'b1, acr_pkg::ADDR_CFG})
                  begin
                     state_next = acr_pkg::ST_RD_CFG;
                     tx_next = {cfg_reg, {(acr_pkg::DATA_W-acr_pkg::CFG_W){1'b0}}};
                  end
                  else if (rx_shift == {1'b1, acr_pkg::ADDR_DATA})
                  begin
                     state_next = acr_pkg::ST_RD_DATA;
                     tx_next = fmt_word;
                  end
                  else if (rx_shift == {1'b0, acr_pkg::ADDR_CFG})
                     state_next = acr_pkg::ST_WR_CFG;
                  else
                     state_next = acr_pkg::ST_SKIP;
               end
            end
            default:
            begin
            end
         endcase
      end
      else if (sclk_rise)
      begin
         // output changes on rising edges; downstream bits follow our own
         if (state_reg == acr_pkg::ST_RD_CFG || state_reg == acr_pkg::ST_RD_DATA)
         begin
            dout_next = tx_reg[acr_pkg::DATA_W-1];
            tx_next = {tx_reg[acr_pkg::DATA_W-2:0], casc_s};
         end
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         state_reg <= acr_pkg::ST_IDLE;
         sclk_prev_reg <= 1'b1;
         cs_prev_reg <= 1'b1;
         cnt_reg <= '0;
         rx_reg <= '0;
         tx_reg <= '0;
         dout_reg <= 1'b0;
         dout_oe_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         sclk_prev_reg <= sclk_s;
         cs_prev_reg <= cs_n_s;
         cnt_reg <= cnt_next;
         rx_reg <= rx_next;
         tx_reg <= tx_next;
         dout_reg <= dout_next;
         dout_oe_reg <= ~cs_n_s;
      end
   end

   assign dout_out = dout_reg;
   assign dout_oe_out = dout_oe_reg;

   ////////////////////////////////////////////////////////////////////////////
   // device control register
   logic [acr_pkg::CFG_W-1:0] cfg_next;
   logic realign_reg;
   logic realign_next;
   logic soft_rst;

   assign soft_rst = cfg_write_go && rx_reg[acr_pkg::SOFT_RST_BIT];

   always_comb
   begin
      cfg_next = cfg_reg;
      realign_next = 1'b0;
      if (soft_rst)
      begin
         cfg_next = acr_pkg::CFG_RESET;
         realign_next = 1'b1;
      end
      else if (cfg_write_go)
         cfg_next = rx_reg & acr_pkg::CFG_WRITE_MASK;
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         cfg_reg <= acr_pkg::CFG_RESET;
         realign_reg <= 1'b0;
      end
      else
      begin
         cfg_reg <= cfg_next;
         realign_reg <= realign_next;
      end
   end

   logic pdn;
   assign pdn = cfg_reg[acr_pkg::PDN_BIT];
   assign power_down_bit_out = pdn;
   assign osc_enable_out = cfg_reg[acr_pkg::XTAL_BIT] & ~pdn;
   assign fault_circuit_enable_out = ~cfg_reg[acr_pkg::FAULT_DIS_BIT] & ~pdn;
   assign bandgap_enable_out = ~pdn;
   assign ref_buffer_enable_out = ~cfg_reg[acr_pkg::REFBUF_PD_BIT] & ~pdn;
   assign full_resolution_select_out = cfg_reg[acr_pkg::FULL_RES_BIT];
   assign realign_out = realign_reg;

   ////////////////////////////////////////////////////////////////////////////
   // buffered clock output, driven only while the oscillator runs
   logic clk_out_reg;
   logic clk_oe_reg;

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         clk_out_reg <= 1'b0;
         clk_oe_reg <= 1'b0;
      end
      else
      begin
         clk_out_reg <= xin_s;
         clk_oe_reg <= osc_enable_out;
      end
   end

   assign buffered_clock_out_out = clk_out_reg;
   assign buffered_clock_out_oe_out = clk_oe_reg;

   ////////////////////////////////////////////////////////////////////////////
   // result register and ready strobe
   logic [acr_pkg::RES_W*4-1:0] res_reg;
   logic [acr_pkg::RES_W*4-1:0] res_next;
   logic [acr_pkg::READY_W-1:0] rdy_cnt_reg;
   logic [acr_pkg::READY_W-1:0] rdy_cnt_next;
   logic rdy_n_reg;
   logic rdy_n_next;
   logic load;

   // powered-down modulators deliver nothing
   assign load = conv_valid_in & ~pdn;

   always_comb
   begin
      res_next = res_reg;
      rdy_cnt_next = rdy_cnt_reg;
      rdy_n_next = rdy_n_reg;
      if (soft_rst)
      begin
         res_next = '0;
         rdy_cnt_next = '0;
         rdy_n_next = 1'b1;
      end
      else if (load)
      begin
         // unread results are simply replaced
         res_next = {channel0_result_in, channel1_result_in,
                     channel2_result_in, channel3_result_in};
         rdy_cnt_next = acr_pkg::READY_W'(acr_pkg::READY_HIGH_CYCLES);
         rdy_n_next = 1'b1;
      end
      else if (rdy_cnt_reg != '0)
      begin
         rdy_cnt_next = rdy_cnt_reg - 4'h1;
         if (rdy_cnt_reg == 4'h1)
            rdy_n_next = 1'b0;
      end
      else if (data_read_go)
         rdy_n_next = 1'b1;
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         res_reg <= '0;
         rdy_cnt_reg <= '0;
         rdy_n_reg <= 1'b1;
      end
      else
      begin
         res_reg <= res_next;
         rdy_cnt_reg <= rdy_cnt_next;
         rdy_n_reg <= rdy_n_next;
      end
   end

   assign result_ready_out_n = rdy_n_reg;

   acr_result_format
   #(
      .SIXTEEN_BIT(SIXTEEN_BIT)
   )
   u_format
   (
      .results_in(res_reg),
      .position_tag_in(cascade_position_tag_in),
      .full_res_in(cfg_reg[acr_pkg::FULL_RES_BIT]),
      .word_out(fmt_word)
   );

   ////////////////////////////////////////////////////////////////////////////
   // overvoltage clipping and recovery hold
   logic [acr_pkg::RECOV_W-1:0] recov_reg;
   logic [acr_pkg::RECOV_W-1:0] recov_next;
   logic clip_reg;
   logic clip_next;

   always_comb
   begin
      recov_next = recov_reg;
      clip_next = 1'b0;
      if (!fault_circuit_enable_out)
         recov_next = '0;
      else if (fault_s)
      begin
         recov_next = acr_pkg::RECOV_W'(FAULT_RECOVERY_CYCLES);
         clip_next = 1'b1;
      end
      else if (recov_reg != '0)
      begin
         recov_next = recov_reg - 18'h00001;
         clip_next = 1'b1;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         recov_reg <= '0;
         clip_reg <= 1'b0;
      end
      else
      begin
         recov_reg <= recov_next;
         clip_reg <= clip_next;
      end
   end

   assign clip_active_out = clip_reg;
endmodule // acr_top
`default_nettype wire

//--- testbench/acr_host_model.sv
// host serial master model for the converter port
`timescale 1ns/1ps
`default_nettype none
module acr_host_model
(
   // clock
   input wire logic core_clk_in,
   // serial port
   output logic cs_n_out,
   output logic sclk_out,
   output logic din_out,
   input wire logic dout_in
);
   initial
   begin
      cs_n_out = 1'b1;
      sclk_out = 1'b1;
      din_out = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // one frame: command byte then n data bits, msb first; n is 8 or 96 per device
   task automatic xfer(input logic [7:0] cmd, input int n, input logic [95:0] wd,
      output logic [95:0] rd);
      logic [103:0] sh;
      int i;
      sh = {cmd, wd};
      rd = '0;
      @(posedge core_clk_in);
      cs_n_out <= 1'b0;
      din_out <= sh[103];
      repeat (8) @(posedge core_clk_in);
      for (i = 0; i < 8 + n; i++)
      begin
         // clock high eight cycles, then sample just before the falling edge
         repeat (7) @(posedge core_clk_in);
         @(negedge core_clk_in);
         if (i >= 8)
            rd = {rd[94:0], dout_in};
         @(posedge core_clk_in);
         sclk_out <= 1'b0;
         repeat (8) @(posedge core_clk_in);
         sclk_out <= 1'b1;
         if (i < 103)
            din_out <= sh[102-i];
      end
      repeat (8) @(posedge core_clk_in);
      cs_n_out <= 1'b1;
      // released line shows the inverse, not a stale level
      din_out <= ~din_out;
      repeat (8) @(posedge core_clk_in);
   endtask
endmodule // acr_host_model
`default_nettype wire

//--- testbench/acr_monitor.sv
// port checker for the converter register and result block
`timescale 1ns/1ps
`default_nettype none
module acr_monitor
#(
   parameter int FAULT_RECOVERY_CYCLES = 20
)
(
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic cs_n_in,
   input wire logic fault_in,
   input wire logic conv_valid_in,
   input wire logic dout_oe_out,
   input wire logic result_ready_out_n,
   input wire logic buffered_clock_out_oe_out,
   input wire logic power_down_bit_out,
   input wire logic osc_enable_out,
   input wire logic fault_circuit_enable_out,
   input wire logic bandgap_enable_out,
   input wire logic full_resolution_select_out,
   input wire logic realign_out,
   input wire logic clip_active_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rst_n_in);
   ////////////////////////////////////////////////////////////////////////////
   // cycles since the fault pin was last high
   int since_reg;
   int since_next;
   always_comb
   begin
      since_next = fault_in ? 0 : since_reg + 1;
      if (since_reg > 1000000)
         since_next = since_reg;
   end
   always_ff @(posedge core_clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
         since_reg <= 0;
      else
         since_reg <= since_next;
   end
   sequence cs_idle;
      cs_n_in [*6];
   endsequence
   sequence flt_held;
      fault_in [*5];
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   a_pdn_all_off: assert property (
      power_down_bit_out |-> !osc_enable_out && !fault_circuit_enable_out && !bandgap_enable_out)
      else $error("power down leaves a circuit on");
   a_buffered_clock_out_drive: assert property (
      buffered_clock_out_oe_out == $past(osc_enable_out))
      else $error("clock out driven while oscillator off");
   a_ready_falls: assert property (
      conv_valid_in |=> result_ready_out_n ##[1:6] !result_ready_out_n)
      else $error("ready did not fall after conversion");
   a_oe_idle_off: assert property (
      cs_idle |-> !dout_oe_out)
      else $error("data out driven while deselected");
   a_realign_once: assert property (
      realign_out |=> !realign_out)
      else $error("realign longer than one cycle");
   a_realign_clear: assert property (
      realign_out |-> ##[0:1] (!power_down_bit_out && !full_resolution_select_out
      && !osc_enable_out))
      else $error("soft reset left control bits set");
   a_clip_dis_off: assert property (
      !fault_circuit_enable_out && !$past(fault_circuit_enable_out) |-> !clip_active_out)
      else $error("clip active with protection off");
   a_fault_clips: assert property (
      flt_held ##0 fault_circuit_enable_out |-> clip_active_out)
      else $error("fault did not clip output");
   a_clip_hold: assert property (
      $fell(clip_active_out) && fault_circuit_enable_out |->
      since_reg >= FAULT_RECOVERY_CYCLES && since_reg <= FAULT_RECOVERY_CYCLES + 6)
      else $error("clip recovery time wrong");
endmodule // acr_monitor
bind acr_top acr_monitor #(.FAULT_RECOVERY_CYCLES(FAULT_RECOVERY_CYCLES)) acr_monitor_i (
   .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .fault_in(fault_in),
   .conv_valid_in(conv_valid_in), .dout_oe_out(dout_oe_out),
   .result_ready_out_n(result_ready_out_n),
   .buffered_clock_out_oe_out(buffered_clock_out_oe_out),
   .power_down_bit_out(power_down_bit_out), .osc_enable_out(osc_enable_out),
   .fault_circuit_enable_out(fault_circuit_enable_out),
   .bandgap_enable_out(bandgap_enable_out),
   .full_resolution_select_out(full_resolution_select_out),
   .realign_out(realign_out), .clip_active_out(clip_active_out));
`default_nettype wire

//--- testbench/testbench.sv
// self-checking bench for the converter register and result block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic cs_n, sclk, din, dout, dout_oe, ready_n, cv = 1'b0, flt = 1'b0, clock_input_pin = 1'b0;
   logic buffered_clock_out, buffered_clock_out_oe, pdn, osc, fen, bg, rbuf, full, realign, clip, seen_realign = 1'b0;
   logic [23:0] c0 = '0, c1 = '0, c2 = '0, c3 = '0;
   logic [2:0] tag = '0;
   logic [95:0] rd;
   int fails = 0;
   int n_tests = 0;
   always #5 clk = ~clk;
   always @(posedge clk) clock_input_pin <= ~clock_input_pin;
   always @(posedge clk) if (realign === 1'b1) seen_realign <= 1'b1;
   acr_host_model acr_host_model_i (.core_clk_in(clk), .cs_n_out(cs_n), .sclk_out(sclk),
      .din_out(din), .dout_in(dout));
   // full-resolution variant only, so setting bit 5 is legal here
   acr_top #(.SIXTEEN_BIT(1'b0), .FAULT_RECOVERY_CYCLES(20)) acr_top_i (
      .core_clk_in(clk), .rst_n_in(rst_n), .cs_n_in(cs_n), .sclk_in(sclk), .din_in(din),
      .casc_data_in(1'b0), .dout_out(dout), .dout_oe_out(dout_oe),
      .result_ready_out_n(ready_n), .conv_valid_in(cv), .channel0_result_in(c0),
      .channel1_result_in(c1), .channel2_result_in(c2), .channel3_result_in(c3),
      .cascade_position_tag_in(tag), .fault_in(flt), .clock_input_pin_in(clock_input_pin),
      .buffered_clock_out_out(buffered_clock_out), .buffered_clock_out_oe_out(buffered_clock_out_oe),
      .power_down_bit_out(pdn), .osc_enable_out(osc), .fault_circuit_enable_out(fen),
      .bandgap_enable_out(bg), .ref_buffer_enable_out(rbuf),
      .full_resolution_select_out(full), .realign_out(realign), .clip_active_out(clip));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string nm, input logic [95:0] exp, input logic [95:0] got);
      n_tests++;
      if (got !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic conv(input logic [95:0] r, input logic [2:0] t);
      int n;
      @(posedge clk);
      {c0, c1, c2, c3} <= r;
      tag <= t;
      cv <= 1'b1;
      @(posedge clk);
      cv <= 1'b0;
      // look between edges; ready must be seen high before it falls
      n = 0;
      do
      begin
         @(negedge clk);
         n++;
      end
      while (ready_n !== 1'b0 && n < 20);
      chk("ready_fall", 1, n > 1 && n < 20);
      if (n >= 20)
         results();
   endtask
   // 19-bit slot: result, position tag, channel tag 00..11
   function automatic logic [95:0] f19(input logic [95:0] r, input logic [2:0] t);
      f19 = {r[95:77], t, 2'h0, r[71:53], t, 2'h1, r[47:29], t, 2'h2, r[23:5], t, 2'h3};
   endfunction
   ////////////////////////////////////////////////////////////////////////////
   logic [7:0] wv [6] = '{8'h10, 8'h80, 8'h08, 8'h04, 8'h23, 8'hFC};
   logic [95:0] ra = {24'h800001, 24'h7FFFFF, 24'h123456, 24'hFEDCBA};
   logic [95:0] rb = {24'hC00FE1, 24'h000020, 24'hFFFFE0, 24'h00001F};
   initial
   begin
      repeat (100000) @(posedge clk);
      chk("watchdog", 0, 1);
      results();
   end
   initial
   begin
      logic [7:0] e;
      int n;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      acr_host_model_i.xfer(8'hE0, 8, '0, rd);
      chk("cfg_reset", 8'h00, rd[7:0]);
      chk("outs_reset", 7'b0000111, {pdn, osc, buffered_clock_out_oe, full, fen, bg, rbuf});
      $display("test reset done");
      // each control bit, reserved bits and soft reset
      foreach (wv[k])
      begin
         acr_host_model_i.xfer(8'h60, 8, {wv[k], 88'h0}, rd);
         e = wv[k][6] ? 8'h00 : (wv[k] & 8'hBC);
         acr_host_model_i.xfer(8'hE0, 8, '0, rd);
         chk("cfg_read", e, rd[7:0]);
         chk("cfg_outs", {e[7], e[4] & ~e[7], e[4] & ~e[7], e[5], ~e[3] & ~e[7], ~e[7],
            ~e[2] & ~e[7]},
            {pdn, osc, buffered_clock_out_oe, full, fen, bg, rbuf});
      end
      chk("realign_seen", 1, seen_realign);
      $display("test control done");
      // full width then reduced width of the same conversion
      acr_host_model_i.xfer(8'h60, 8, {8'h20, 88'h0}, rd);
      conv(ra, 3'h5);
      acr_host_model_i.xfer(8'hF0, 96, '0, rd);
      chk("res_24", ra, rd);
      acr_host_model_i.xfer(8'h60, 8, {8'h00, 88'h0}, rd);
      acr_host_model_i.xfer(8'hF0, 96, '0, rd);
      chk("res_19", f19(ra, 3'h5), rd);
      // unread result replaced by the next one
      conv(ra, 3'h0);
      conv(rb, 3'h0);
      acr_host_model_i.xfer(8'hF0, 96, '0, rd);
      chk("res_over", f19(rb, 3'h0), rd);
      $display("test results done");
      // fault recovery, then protection disabled
      @(posedge clk);
      flt <= 1'b1;
      repeat (10) @(posedge clk);
      flt <= 1'b0;
      n = 0;
      @(posedge clk);
      while (clip !== 1'b0 && n < 60)
      begin
         @(posedge clk);
         n++;
      end
      chk("clip_hold", 1, n >= 20 && n <= 26);
      acr_host_model_i.xfer(8'h60, 8, {8'h08, 88'h0}, rd);
      flt <= 1'b1;
      e = 8'h00;
      repeat (14)
      begin
         @(posedge clk);
         e = e | {7'h0, clip !== 1'b0};
         flt <= 1'b0;
      end
      chk("clip_dis", 0, e);
      $display("test fault done");
      results();
   end
endmodule // testbench
`default_nettype wire
